/* rtl/adcseq_top.sv */
// Conversion sequencer top: AHB-Lite slave, sequencer, flags and interrupt
`timescale 1ns/1ps

module adcseq_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Analog core
  output logic [4:0]       core_channel,
  output logic             core_sample,
  input  wire logic [7:0]  core_code,
  // Interrupt
  output logic             irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum {ST_IDLE, ST_CONVERT} adcseq_state_type;

  adcseq_state_type state_reg;
  adcseq_state_type state_next;
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [7:0]  clock_reg;
  logic [7:0]  clock_next;
  logic [0:0]  irq_stat_reg;
  logic [0:0]  irq_stat_next;
  logic [0:0]  irq_mask_reg;
  logic [0:0]  irq_mask_next;
  logic        complete_reg;
  logic        complete_next;
  logic [4:0]  tick_cnt_reg;
  logic [4:0]  tick_cnt_next;
  logic        sample_reg;
  logic        sample_next;
  logic        irq_reg;
  logic        irq_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ph_valid_reg;
  logic        ph_write_reg;
  logic [11:0] ph_addr_reg;
  logic        ph_valid_next;
  logic        ph_write_next;
  logic [11:0] ph_addr_next;
  logic        conv_tick;
  logic        conv_done;
  logic [7:0]  result;
  logic        wr_ctrl;
  logic        rd_data;
  logic        wr_clock;
  logic        wr_stat;
  logic        wr_mask;
  logic        addr_take;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  // Converter clock from selected source and prescaler
  adcseq_clkgen u_clkgen (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clk_select (clock_reg[adcseq_pkg::CLKSEL_BIT]),
    .prescaler  (clock_reg[adcseq_pkg::PRESCALER_LSB +: adcseq_pkg::PRESCALER_W]),
    .conv_tick  (conv_tick)
  );

  // Core code captured straight, 00 at ground, ff at high reference
  adcseq_result u_result (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .load      (conv_done),
    .load_data (core_code),
    .result    (result)
  );

  // ****************************************************************
  // AHB-Lite address phase capture
  // ****************************************************************
  // Zero wait states: the slave is always ready
  always_comb begin
    addr_take     = hsel && hready && htrans[1];
    ph_valid_next = addr_take;
    ph_write_next = addr_take ? hwrite : 1'b0;
    ph_addr_next  = addr_take ? haddr : ph_addr_reg;
  end

  // Register the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 12'h000;
    end else begin
      ph_valid_reg <= ph_valid_next;
      ph_write_reg <= ph_write_next;
      ph_addr_reg  <= ph_addr_next;
    end
  end

  // Data phase strobes
  assign wr_ctrl  = ph_valid_reg && ph_write_reg && (ph_addr_reg == adcseq_pkg::ADDR_STATUS_CONTROL);
  assign wr_clock = ph_valid_reg && ph_write_reg && (ph_addr_reg == adcseq_pkg::ADDR_CLOCK);
  assign wr_stat  = ph_valid_reg && ph_write_reg && (ph_addr_reg == adcseq_pkg::ADDR_IRQ_STATUS);
  assign wr_mask  = ph_valid_reg && ph_write_reg && (ph_addr_reg == adcseq_pkg::ADDR_IRQ_MASK);
  // Read data must be ready at the data phase edge, so decode in address phase
  assign rd_data  = addr_take && !hwrite && (haddr == adcseq_pkg::ADDR_DATA);

  // ****************************************************************
  // Read mux, registered for the data phase
  // ****************************************************************
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (addr_take && !hwrite) begin
      case (haddr)
        adcseq_pkg::ADDR_STATUS_CONTROL: rdata_next = {24'h000000, complete_reg, ctrl_reg[6:0]};
        adcseq_pkg::ADDR_DATA:           rdata_next = {24'h000000, result};
        adcseq_pkg::ADDR_CLOCK:          rdata_next = {24'h000000, clock_reg};
        adcseq_pkg::ADDR_IRQ_STATUS:     rdata_next = {31'h00000000, irq_stat_reg};
        adcseq_pkg::ADDR_IRQ_MASK:       rdata_next = {31'h00000000, irq_mask_reg};
        default:                         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register the read data for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Sequencer: state, converter tick count and sample strobe
  // ****************************************************************
  // Count reached on the last tick: seventeen ticks counted from zero
  localparam logic [4:0] DONE_COUNT   = adcseq_pkg::CONV_CYCLES - 5'h01;
  // Strobe two ticks early, so the core answers before the capture
  localparam logic [4:0] SAMPLE_COUNT = 5'(adcseq_pkg::CONV_CYCLES_MAX - 2 - adcseq_pkg::CORE_LATENCY);

  // The first tick may come early, so the span is 16 to 17 periods
  assign conv_done = (state_reg == ST_CONVERT) && conv_tick && (tick_cnt_reg == DONE_COUNT);

  // Next sequencer state
  always_comb begin
    state_next    = state_reg;
    tick_cnt_next = tick_cnt_reg;
    sample_next   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        tick_cnt_next = 5'h00;
      end
      ST_CONVERT: begin
        if (conv_tick) begin
          tick_cnt_next = tick_cnt_reg + 5'h01;
          // At full rate a later strobe would race the capture edge
          if (tick_cnt_reg == SAMPLE_COUNT) begin
            sample_next = 1'b1;
          end
        end
        if (conv_done) begin
          tick_cnt_next = 5'h00;
          if (ctrl_reg[adcseq_pkg::BIT_CONTINUOUS]) begin
            state_next = ST_CONVERT;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Any control write restarts, including mid conversion
    if (wr_ctrl) begin
      state_next    = ST_CONVERT;
      tick_cnt_next = 5'h00;
    end
  end

  // Register sequencer state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= ST_IDLE;
      tick_cnt_reg <= 5'h00;
      sample_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      sample_reg   <= sample_next;
    end
  end

  // ****************************************************************
  // Software registers: control, converter clock, interrupt mask
  // ****************************************************************
  // Next register values on data phase writes
  always_comb begin
    ctrl_next     = ctrl_reg;
    clock_next    = clock_reg;
    irq_mask_next = irq_mask_reg;
    // Flag position is read only, kept zero in storage
    if (wr_ctrl) begin
      ctrl_next = {1'b0, hwdata[6:0]};
    end
    if (wr_clock) begin
      clock_next = hwdata[7:0];
    end
    if (wr_mask) begin
      irq_mask_next = hwdata[0:0];
    end
  end

  // Register the software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= adcseq_pkg::STATUS_CONTROL_RESET;
      clock_reg    <= adcseq_pkg::CLOCK_RESET;
      irq_mask_reg <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      clock_reg    <= clock_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ****************************************************************
  // Completion flag, interrupt status and interrupt line
  // ****************************************************************
  // Next flag values; clears first so a done in the same cycle wins
  always_comb begin
    complete_next = complete_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_stat) begin
      irq_stat_next = irq_stat_reg & ~hwdata[0:0];
    end
    // Flag drops on data read or control write
    if (rd_data || wr_ctrl) begin
      complete_next = 1'b0;
    end
    if (conv_done) begin
      if (ctrl_reg[adcseq_pkg::BIT_IRQ_ENABLE]) begin
        // Only ever sets, so a pending event survives a quiet done
        irq_stat_next[adcseq_pkg::IRQ_DONE_BIT] = 1'b1;
      end else begin
        complete_next = 1'b1;
      end
    end
    // Enabled interrupts keep the flag at zero
    if (ctrl_next[adcseq_pkg::BIT_IRQ_ENABLE]) begin
      complete_next = 1'b0;
    end
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  // Register the flags and the interrupt line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      complete_reg <= 1'b0;
      irq_stat_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      complete_reg <= complete_next;
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= irq_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata       = rdata_reg;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign core_channel = ctrl_reg[adcseq_pkg::CHANNEL_LSB +: adcseq_pkg::CHANNEL_W];
  assign core_sample  = sample_reg;
  assign irq          = irq_reg;

endmodule

/* rtl/adcseq_pkg.sv */
// Package with register map, field positions and timing constants of the conversion sequencer
package adcseq_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h038;
  localparam logic [11:0] ADDR_DATA           = 12'h03c;
  localparam logic [11:0] ADDR_CLOCK          = 12'h040;
  localparam logic [11:0] ADDR_IRQ_STATUS     = 12'h044;
  localparam logic [11:0] ADDR_IRQ_MASK       = 12'h048;

  // ****************************************************************
  // Status and control fields
  // ****************************************************************
  localparam int BIT_COMPLETE   = 7;
  localparam int BIT_IRQ_ENABLE = 6;
  localparam int BIT_CONTINUOUS = 5;
  localparam int CHANNEL_LSB    = 0;
  localparam int CHANNEL_W      = 5;

  // ****************************************************************
  // Clock register fields
  // ****************************************************************
  localparam int PRESCALER_LSB = 5;
  localparam int PRESCALER_W   = 3;
  localparam int CLKSEL_BIT    = 4;

  // ****************************************************************
  // Interrupt status bits
  // ****************************************************************
  localparam int IRQ_W        = 1;
  localparam int IRQ_DONE_BIT = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h1f;
  localparam logic [7:0] CLOCK_RESET          = 8'h00;

  // ****************************************************************
  // Conversion timing in converter clock cycles
  // ****************************************************************
  localparam int          CONV_CYCLES_MIN = 16;
  localparam int          CONV_CYCLES_MAX = 17;
  localparam logic [4:0]  CONV_CYCLES     = 5'h11;

  // Crystal reference rate and its divide from hclk
  localparam int          HCLK_MHZ    = 100;
  localparam int          XTAL_MHZ    = 4;
  localparam int          XTAL_DIV    = HCLK_MHZ / XTAL_MHZ;
  localparam logic [7:0]  XTAL_DIV_M1 = 8'(XTAL_DIV - 1);

  // Converter core answer latency in hclk cycles after a sample strobe
  localparam int          CORE_LATENCY = 1;

endpackage

/* rtl/adcseq_clkgen.sv */
// Converter clock generator: source select plus power-of-two prescaler
`timescale 1ns/1ps

module adcseq_clkgen (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Configuration
  input  wire logic       clk_select,
  input  wire logic [2:0] prescaler,
  // Converter clock enable
  output logic            conv_tick
);

  // ****************************************************************
  // Source tick: bus clock every cycle, or crystal reference
  // ****************************************************************
  logic [7:0]  xtal_cnt_reg;
  logic [7:0]  xtal_cnt_next;
  logic        src_tick;
  logic [6:0]  pre_cnt_reg;
  logic [6:0]  pre_cnt_next;
  logic        tick_reg;
  logic        tick_next;
  logic [6:0]  pre_mask;

  // Next values of both dividers
  always_comb begin
    xtal_cnt_next = (xtal_cnt_reg == adcseq_pkg::XTAL_DIV_M1) ? 8'h00 : xtal_cnt_reg + 8'h01;
    src_tick      = clk_select ? 1'b1 : (xtal_cnt_reg == adcseq_pkg::XTAL_DIV_M1);
    // Prescale values above seven saturate at divide by 128
    pre_mask      = 7'((8'h01 << ((prescaler > 3'h7) ? 3'h7 : prescaler)) - 8'h01);
    pre_cnt_next  = pre_cnt_reg;
    tick_next     = 1'b0;
    if (src_tick) begin
      if ((pre_cnt_reg & pre_mask) == pre_mask) begin
        pre_cnt_next = 7'h00;
        tick_next    = 1'b1;
      end else begin
        pre_cnt_next = pre_cnt_reg + 7'h01;
      end
    end
  end

  // Register the dividers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_cnt_reg <= 8'h00;
      pre_cnt_reg  <= 7'h00;
      tick_reg     <= 1'b0;
    end else begin
      xtal_cnt_reg <= xtal_cnt_next;
      pre_cnt_reg  <= pre_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  assign conv_tick = tick_reg;

endmodule

/* rtl/adcseq_result.sv */
// Result holding register, loaded at the end of each conversion
`timescale 1ns/1ps

module adcseq_result (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Write side
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  // Read side
  output logic [7:0]      result
);

  // ****************************************************************
  // Result storage
  // ****************************************************************
  logic [7:0] result_reg;
  logic [7:0] result_next;

  // Overwrites on every load, read or not
  always_comb begin
    result_next = load ? load_data : result_reg;
  end

  // Register the result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg <= 8'h00;
    end else begin
      result_reg <= result_next;
    end
  end

  assign result = result_reg;

endmodule

/* dv/adcseq_core_model.sv */
// Behavioural analog core that answers the sequencer's sample strobe
`timescale 1ns/1ps

module adcseq_core_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Sequencer side
  input  wire logic [4:0] core_channel,
  input  wire logic       core_sample,
  output logic [7:0]      core_code
);
  logic [7:0] ramp_reg;
  logic       held_reg;

  // Level per channel: 0 high reference, 1 ground, 3 ramps per sample
  function automatic logic [7:0] level(logic [4:0] ch, logic [7:0] r);
    case (ch)
      5'h00: level = 8'hff;
      5'h01: level = 8'h00;
      5'h03: level = r;
      default: level = {ch, 3'h0};
    endcase
  endfunction

  // Toggle before the first strobe so a stale code never looks valid
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_reg  <= 8'h00;
      held_reg  <= 1'b0;
      core_code <= 8'h5a;
    end else if (core_sample) begin
      ramp_reg  <= ramp_reg + 8'h01;
      held_reg  <= 1'b1;
      core_code <= level(core_channel, ramp_reg + 8'h01);
    end else if (!held_reg) begin
      core_code <= ~core_code;
    end
  end
endmodule

/* dv/adcseq_sva.sv */
// Checker of bus, strobe and interrupt behaviour at the sequencer's ports
`timescale 1ns/1ps

module adcseq_sva (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Core and interrupt
  input wire logic [4:0]  core_channel,
  input wire logic        core_sample,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Accepted address phases
  wire take   = hsel && hready && htrans[1];
  wire ctl_wr = take && hwrite && haddr == adcseq_pkg::ADDR_STATUS_CONTROL;
  wire irq_wr = take && hwrite && (haddr == adcseq_pkg::ADDR_IRQ_STATUS || haddr == adcseq_pkg::ADDR_IRQ_MASK);
  wire mapped = haddr inside {[12'h038:12'h048]} && haddr[1:0] == 2'h0;

  // Write takes effect at the end of its data phase
  sequence ctl_update;
    ctl_wr ##1 1'b1;
  endsequence
  sequence rd_unmapped;
    take && !hwrite && !mapped;
  endsequence

  a_ready_high:
    assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay:
    assert property (!hresp) else $error("error response");
  a_sample_single:
    assert property (core_sample |=> !core_sample) else $error("strobe too long");
  a_channel_follows:
    assert property (ctl_update |=> core_channel == $past(hwdata[4:0])) else $error("channel not loaded");
  a_channel_held:
    assert property ($changed(core_channel) |-> $past(ctl_wr, 2)) else $error("channel moved alone");
  a_unmapped_zero:
    assert property (rd_unmapped |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_upper_zero:
    assert property (take && !hwrite |=> hrdata[31:8] == 24'h0) else $error("upper bits set");
  a_irq_quiet:
    assert property ($rose(hresetn) |-> !irq [*8]) else $error("irq after reset");
  a_irq_cleared:
    assert property ($fell(irq) |-> $past(irq_wr, 2) || $past(irq_wr, 3) || $past(irq_wr, 4))
      else $error("irq fell alone");
endmodule

bind adcseq_top adcseq_sva chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .core_channel(core_channel),
  .core_sample(core_sample), .irq(irq)
);

/* dv/adcseq_test.sv */
// Self-checking bench of the conversion sequencer through its bus
`timescale 1ns/1ps

module adcseq_test;
  localparam logic [11:0] CTL = adcseq_pkg::ADDR_STATUS_CONTROL;
  localparam logic [11:0] DAT = adcseq_pkg::ADDR_DATA;
  localparam logic [11:0] CLK = adcseq_pkg::ADDR_CLOCK;
  localparam logic [11:0] IST = adcseq_pkg::ADDR_IRQ_STATUS;
  localparam logic [11:0] IMK = adcseq_pkg::ADDR_IRQ_MASK;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, core_sample, irq;
  logic [4:0]  core_channel;
  logic [7:0]  core_code;
  logic [4:0]  chan [3] = '{5'h00, 5'h01, 5'h05};
  logic [7:0]  code [3] = '{8'hff, 8'h00, 8'h28};
  int          fail_count = 0;
  int          cmp_count = 0;
  int          samples = 0;
  int          t0, n, d1;

  // ********
  // Clock, strobe count, models
  // ********
  always #5 hclk = ~hclk;
  always @(posedge hclk) if (core_sample === 1'b1) samples++;
  adcseq_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_channel(core_channel), .core_sample(core_sample),
    .core_code(core_code), .irq(irq));
  adcseq_core_model core_u (.hclk(hclk), .hresetn(hresetn), .core_channel(core_channel),
    .core_sample(core_sample), .core_code(core_code));

  // ********
  // Compare and bus tasks
  // ********
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_in(string nm, int lo, int hi, int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // One single transfer; holds each phase until hready is seen high
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(string nm, logic [11:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // Poll the complete flag; t0 ends as elapsed cycles
  task automatic wait_flag(int lim);
    t0 = int'($time / 10);
    n = 0;
    do begin
      bus(1'b0, CTL, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < lim);
    t0 = int'($time / 10) - t0;
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected thousand or so cycles
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("ctrl reset", CTL, 32'h1f);
    rchk("clock reset", CLK, 32'h0);
    rchk("irq status reset", IST, 32'h0);
    bus(1'b1, 12'h04c, 32'hff);
    rchk("unmapped", 12'h04c, 32'h0);
    bus(1'b1, CLK, 32'h10);
    foreach (chan[i]) begin
      bus(1'b1, CTL, {27'h0, chan[i]});
      wait_flag(60);
      chk_in("cycles fast", 18, 20, t0);
      rchk("code", DAT, {24'h0, code[i]});
      rchk("flag read clear", CTL, {27'h0, chan[i]});
    end
    n = samples;
    repeat (60) @(posedge hclk);
    chk_in("idle strobes", n, n, samples);
    // Divide by two, then the slow crystal reference
    bus(1'b1, CLK, 32'h30);
    bus(1'b1, CTL, 32'h02);
    wait_flag(60);
    chk_in("cycles div2", 34, 37, t0);
    bus(1'b1, CLK, 32'h00);
    bus(1'b1, CTL, 32'h02);
    wait_flag(300);
    chk_in("cycles crystal", 402, 428, t0);
    bus(1'b1, CLK, 32'h10);
    // Continuous on the ramp channel
    bus(1'b1, CTL, 32'h23);
    wait_flag(60);
    repeat (60) @(posedge hclk);
    rchk("flag held", CTL, 32'ha3);
    n = samples;
    bus(1'b0, DAT, 32'h0);
    d1 = int'(rd[7:0]);
    repeat (68) @(posedge hclk);
    bus(1'b0, DAT, 32'h0);
    chk_in("overwrites", 3, 5, int'(rd[7:0]) - d1);
    chk_in("repeat strobes", 3, 5, samples - n);
    bus(1'b1, CTL, 32'h03);
    n = samples;
    repeat (80) @(posedge hclk);
    // The write itself starts one last conversion; one more may be in flight
    chk_in("stopped", 1, 2, samples - n);
    // Interrupt raised, cleared, masked, unmasked
    bus(1'b1, IMK, 32'h1);
    bus(1'b1, CTL, 32'h40);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk("irq raised", 32'h1, {31'h0, irq});
    rchk("flag low", CTL, 32'h40);
    rchk("irq status", IST, 32'h1);
    bus(1'b1, IST, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b1, IMK, 32'h0);
    bus(1'b1, CTL, 32'h40);
    repeat (40) @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rchk("masked status", IST, 32'h1);
    bus(1'b1, IMK, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    bus(1'b1, IST, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq off", 32'h0, {31'h0, irq});
    wrap_up();
  end
endmodule
